/* File: rtl/rcjs_defs.vh */
// Summary of operation
// - control bit 7 switches rate converter on
// - control bit 6 set disables automatic rate detection
// - ratio bit 7 picks inferred or manual rate
// - source bit 6 picks primary or secondary port
// - numerator code maps 0 auto,1-4,6; 5,7 banned
// - denominator code maps 0 auto,1-4,6; 5,7 banned
// - pulse rate 0.5, 1, 7.5, 15 Hz
// - pulse high time 4 ms or 32 ms
// - headphone tick 1, 2, 4 ms; code 3 banned
// - threshold bit picks hook and microphone limits
// - four 8-bit registers 0x17-0x1A reset 0x00
// - coupling bit 3: 0 AC, 1 DC
// - headset sensing runs only when enable set
`ifndef RCJS_DEFS_VH
`define RCJS_DEFS_VH

// clock
`define RCJS_CLK_NS         100
`define RCJS_CYC_PER_US     (1000 / `RCJS_CLK_NS)

// register offsets
`define RCJS_ADDR_CTRL      8'h17
`define RCJS_ADDR_RATIO     8'h18
`define RCJS_ADDR_TIMING    8'h19
`define RCJS_ADDR_THRESH    8'h1A
`define RCJS_RESET_VAL      8'h00

// writable bit masks, reserved read-only bits read zero
`define RCJS_WMASK_CTRL     8'hC0
`define RCJS_WMASK_RATIO    8'hFF
`define RCJS_WMASK_TIMING   8'hFF
`define RCJS_WMASK_THRESH   8'hFE

// field positions
`define RCJS_BIT_CONV_ON    7
`define RCJS_BIT_AUTO_OFF   6
`define RCJS_BIT_MANUAL     7
`define RCJS_BIT_SOURCE     6
`define RCJS_NUM_HI         5
`define RCJS_NUM_LO         3
`define RCJS_DEN_HI         2
`define RCJS_DEN_LO         0
`define RCJS_RATE_HI        7
`define RCJS_RATE_LO        6
`define RCJS_BIT_HIGHTIME   5
`define RCJS_TICK_HI        2
`define RCJS_TICK_LO        1
`define RCJS_BIT_HOOKSEL    6
`define RCJS_BIT_COUPLING   3
`define RCJS_BIT_SENSE_ON   1

// ratio codes
`define RCJS_RATIO_AUTO     3'h0
`define RCJS_RATIO_SIX      3'h6
`define RCJS_RATIO_RES5     3'h5
`define RCJS_RATIO_RES7     3'h7

// codes of the timing fields
`define RCJS_RATE_0P5HZ     2'h0
`define RCJS_RATE_1HZ       2'h1
`define RCJS_RATE_7P5HZ     2'h2
`define RCJS_TICK_1MS       2'h0
`define RCJS_TICK_2MS       2'h1
`define RCJS_TICK_4MS       2'h2
`define RCJS_TICK_RES       2'h3

// times in microseconds
`define RCJS_T_0P5HZ_US     2000000
`define RCJS_T_1HZ_US       1000000
`define RCJS_T_7P5HZ_US     133333
`define RCJS_T_15HZ_US      66666
`define RCJS_T_HIGH4_US     4000
`define RCJS_T_HIGH32_US    32000
`define RCJS_T_TICK1_US     1000
`define RCJS_T_TICK2_US     2000
`define RCJS_T_TICK4_US     4000

// cycle counts derived from the clock
`define RCJS_CYC_0P5HZ      (`RCJS_T_0P5HZ_US * `RCJS_CYC_PER_US)
`define RCJS_CYC_1HZ        (`RCJS_T_1HZ_US * `RCJS_CYC_PER_US)
`define RCJS_CYC_7P5HZ      (`RCJS_T_7P5HZ_US * `RCJS_CYC_PER_US)
`define RCJS_CYC_15HZ       (`RCJS_T_15HZ_US * `RCJS_CYC_PER_US)
`define RCJS_CYC_HIGH4      (`RCJS_T_HIGH4_US * `RCJS_CYC_PER_US)
`define RCJS_CYC_HIGH32     (`RCJS_T_HIGH32_US * `RCJS_CYC_PER_US)
`define RCJS_CYC_TICK1      (`RCJS_T_TICK1_US * `RCJS_CYC_PER_US)
`define RCJS_CYC_TICK2      (`RCJS_T_TICK2_US * `RCJS_CYC_PER_US)
`define RCJS_CYC_TICK4      (`RCJS_T_TICK4_US * `RCJS_CYC_PER_US)
`define RCJS_CNT_W          25

// impedance limits in ohms
`define RCJS_OHM_W          11
`define RCJS_MIC_800        11'h320
`define RCJS_MIC_1350       11'h546
`define RCJS_MIC_1750       11'h6D6
`define RCJS_HOOK_320       11'h140
`define RCJS_HOOK_150       11'h096
`define RCJS_HOOK_680       11'h2A8

`endif

/* File: rtl/rcjs_tick_gen.v */
`timescale 1ns/1ns
`include "rcjs_defs.vh"

module rcjs_tick_gen (
	// clock and reset
	input  wire                   ref_clk_i,
	input  wire                   rst_i,
	// control
	input  wire                   run_i,
	input  wire [`RCJS_CNT_W-1:0] period_i,
	// output
	output reg                    tick_o
);

	reg [`RCJS_CNT_W-1:0] cnt_r;

	// counts period_i cycles, then a one-cycle tick; stopped when not running
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r  <= {`RCJS_CNT_W{1'b0}};
			tick_o <= 1'b0;
		end else if (!run_i) begin
			cnt_r  <= {`RCJS_CNT_W{1'b0}};
			tick_o <= 1'b0;
		end else if (cnt_r >= period_i - {{(`RCJS_CNT_W-1){1'b0}}, 1'b1}) begin
			cnt_r  <= {`RCJS_CNT_W{1'b0}};  // >= copes with a shortened period
			tick_o <= 1'b1;
		end else begin
			cnt_r  <= cnt_r + {{(`RCJS_CNT_W-1){1'b0}}, 1'b1};
			tick_o <= 1'b0;
		end
	end

endmodule // rcjs_tick_gen

/* File: rtl/rcjs_cfg_top.v */
`timescale 1ns/1ns
`include "rcjs_defs.vh"

module rcjs_cfg_top #(
	parameter [`RCJS_CNT_W-1:0] PER_0P5HZ_CYC = `RCJS_CYC_0P5HZ,
	parameter [`RCJS_CNT_W-1:0] PER_1HZ_CYC   = `RCJS_CYC_1HZ,
	parameter [`RCJS_CNT_W-1:0] PER_7P5HZ_CYC = `RCJS_CYC_7P5HZ,
	parameter [`RCJS_CNT_W-1:0] PER_15HZ_CYC  = `RCJS_CYC_15HZ,
	parameter [`RCJS_CNT_W-1:0] HIGH4_CYC     = `RCJS_CYC_HIGH4,
	parameter [`RCJS_CNT_W-1:0] HIGH32_CYC    = `RCJS_CYC_HIGH32,
	parameter [`RCJS_CNT_W-1:0] TICK1_CYC     = `RCJS_CYC_TICK1,
	parameter [`RCJS_CNT_W-1:0] TICK2_CYC     = `RCJS_CYC_TICK2,
	parameter [`RCJS_CNT_W-1:0] TICK4_CYC     = `RCJS_CYC_TICK4
) (
	// clock and reset
	input  wire                   ref_clk_i,
	input  wire                   rst_i,
	// register access from the control port
	input  wire                   reg_wr_i,
	input  wire                   reg_rd_i,
	input  wire [7:0]             reg_addr_i,
	input  wire [7:0]             reg_wdata_i,
	output reg  [7:0]             reg_rdata_o,
	output reg                    reg_hit_o,
	// rate converter controls
	output reg                    rate_converter_on_o,
	output reg                    rate_autodetect_on_o,
	output reg                    main_rate_manual_o,
	output reg                    main_rate_source_o,
	output reg  [2:0]             ratio_num_o,
	output reg  [2:0]             ratio_den_o,
	// headset and headphone sensing
	output reg                    headset_sense_on_o,
	output reg                    sense_pulse_o,
	output wire                   headphone_sense_tick_o,
	output reg                    headphone_coupling_kind_o,
	output reg  [`RCJS_OHM_W-1:0] mic_min_ohm_o,
	output reg  [`RCJS_OHM_W-1:0] hook_max_ohm_o
);

	// register bank
	reg [7:0] ctrl_r;
	reg [7:0] ratio_r;
	reg [7:0] timing_r;
	reg [7:0] thresh_r;

	// sensing timers
	reg  [`RCJS_CNT_W-1:0] pulse_per_nxt;
	reg  [`RCJS_CNT_W-1:0] high_cyc_nxt;
	reg  [`RCJS_CNT_W-1:0] tick_per_nxt;
	reg  [`RCJS_CNT_W-1:0] high_cnt_r;
	wire                   pulse_start;
	wire                   tick_run;
	wire                   sense_on;
	wire [1:0]             tick_code;
	// read path
	reg  [7:0]             rdata_nxt;

	// ratio code to value; reserved codes fall back to automatic inference
	function [2:0] rcjs_ratio_val;
		input [2:0] code;
		begin
			if (code == `RCJS_RATIO_RES5 || code == `RCJS_RATIO_RES7)
				rcjs_ratio_val = `RCJS_RATIO_AUTO;
			else
				rcjs_ratio_val = code;
		end
	endfunction

	// merge written bits under the writable mask
	function [7:0] rcjs_merge;
		input [7:0] old_val;
		input [7:0] wdata;
		input [7:0] wmask;
		begin
			rcjs_merge = (old_val & ~wmask) | (wdata & wmask);
		end
	endfunction

	// true for the four addresses of this bank
	function rcjs_in_bank;
		input [7:0] addr;
		begin
			rcjs_in_bank = (addr >= `RCJS_ADDR_CTRL) && (addr <= `RCJS_ADDR_THRESH);
		end
	endfunction

	// headphone tick code check; the reserved code has no period
	function rcjs_tick_ok;
		input [1:0] code;
		begin
			rcjs_tick_ok = (code != `RCJS_TICK_RES);
		end
	endfunction

	// true on the last cycle of a span of len cycles
	function rcjs_span_done;
		input [`RCJS_CNT_W-1:0] cnt;
		input [`RCJS_CNT_W-1:0] len;
		begin
			rcjs_span_done = (cnt >= len - {{(`RCJS_CNT_W-1){1'b0}}, 1'b1});
		end
	endfunction

	assign sense_on = thresh_r[`RCJS_BIT_SENSE_ON];
	assign tick_code = timing_r[`RCJS_TICK_HI:`RCJS_TICK_LO];

	// register writes; all four come out of reset at zero
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_r   <= `RCJS_RESET_VAL;
			ratio_r  <= `RCJS_RESET_VAL;
			timing_r <= `RCJS_RESET_VAL;
			thresh_r <= `RCJS_RESET_VAL;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				`RCJS_ADDR_CTRL: begin
					ctrl_r <= rcjs_merge(ctrl_r, reg_wdata_i, `RCJS_WMASK_CTRL);
				end
				`RCJS_ADDR_RATIO: begin
					ratio_r <= rcjs_merge(ratio_r, reg_wdata_i, `RCJS_WMASK_RATIO);
				end
				`RCJS_ADDR_TIMING: begin
					timing_r <= rcjs_merge(timing_r, reg_wdata_i, `RCJS_WMASK_TIMING);
				end
				`RCJS_ADDR_THRESH: begin
					thresh_r <= rcjs_merge(thresh_r, reg_wdata_i, `RCJS_WMASK_THRESH);
				end
				default: begin
					ctrl_r <= ctrl_r; // unmapped writes are dropped
				end
			endcase
		end
	end

	// read multiplexer; unmapped addresses give zero
	always @* begin
		rdata_nxt = `RCJS_RESET_VAL;
		case (reg_addr_i)
			`RCJS_ADDR_CTRL: begin
				rdata_nxt = ctrl_r;
			end
			`RCJS_ADDR_RATIO: begin
				rdata_nxt = ratio_r;
			end
			`RCJS_ADDR_TIMING: begin
				rdata_nxt = timing_r;
			end
			`RCJS_ADDR_THRESH: begin
				rdata_nxt = thresh_r;
			end
			default: begin
				rdata_nxt = `RCJS_RESET_VAL;
			end
		endcase
	end

	// read data and hit are registered and held until the next read
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= `RCJS_RESET_VAL;
			reg_hit_o   <= 1'b0;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rdata_nxt;
			reg_hit_o   <= rcjs_in_bank(reg_addr_i);
		end
	end

	// rate converter enables and rate source from the registers
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rate_converter_on_o  <= 1'b0;
			rate_autodetect_on_o <= 1'b1;
			main_rate_manual_o   <= 1'b0;
			main_rate_source_o   <= 1'b0;
		end else begin
			rate_converter_on_o  <= ctrl_r[`RCJS_BIT_CONV_ON];
			rate_autodetect_on_o <= ~ctrl_r[`RCJS_BIT_AUTO_OFF];
			main_rate_manual_o   <= ratio_r[`RCJS_BIT_MANUAL];
			// source only matters in manual mode; inferred rate reports primary
			main_rate_source_o   <= ratio_r[`RCJS_BIT_MANUAL] & ratio_r[`RCJS_BIT_SOURCE];
		end
	end

	// ratio codes decoded; reserved codes fall back to automatic inference
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ratio_num_o <= `RCJS_RATIO_AUTO;
			ratio_den_o <= `RCJS_RATIO_AUTO;
		end else begin
			ratio_num_o <= rcjs_ratio_val(ratio_r[`RCJS_NUM_HI:`RCJS_NUM_LO]);
			ratio_den_o <= rcjs_ratio_val(ratio_r[`RCJS_DEN_HI:`RCJS_DEN_LO]);
		end
	end

	// pulse repetition period
	always @* begin
		case (timing_r[`RCJS_RATE_HI:`RCJS_RATE_LO])
			`RCJS_RATE_0P5HZ: pulse_per_nxt = PER_0P5HZ_CYC;
			`RCJS_RATE_1HZ:   pulse_per_nxt = PER_1HZ_CYC;
			`RCJS_RATE_7P5HZ: pulse_per_nxt = PER_7P5HZ_CYC;
			default:          pulse_per_nxt = PER_15HZ_CYC;
		endcase
	end

	// pulse high time
	always @* begin
		if (timing_r[`RCJS_BIT_HIGHTIME])
			high_cyc_nxt = HIGH32_CYC;
		else
			high_cyc_nxt = HIGH4_CYC;
	end

	// headphone tick period
	always @* begin
		case (tick_code)
			`RCJS_TICK_1MS: tick_per_nxt = TICK1_CYC;
			`RCJS_TICK_2MS: tick_per_nxt = TICK2_CYC;
			`RCJS_TICK_4MS: tick_per_nxt = TICK4_CYC;
			default:        tick_per_nxt = TICK4_CYC; // reserved code, tick halted below
		endcase
	end

	// reserved tick code stops the headphone tick rather than guess a period
	assign tick_run = sense_on && rcjs_tick_ok(tick_code);

	// pulse repetition timer
	rcjs_tick_gen u_pulse_rate (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.run_i     (sense_on),
		.period_i  (pulse_per_nxt),
		.tick_o    (pulse_start)
	);

	// headphone sense clock
	rcjs_tick_gen u_hp_tick (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.run_i     (tick_run),
		.period_i  (tick_per_nxt),
		.tick_o    (headphone_sense_tick_o)
	);

	// detection pulse: high for the selected time after each start
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sense_pulse_o <= 1'b0;
			high_cnt_r    <= {`RCJS_CNT_W{1'b0}};
		end else if (!sense_on) begin
			sense_pulse_o <= 1'b0;
			high_cnt_r    <= {`RCJS_CNT_W{1'b0}};
		end else if (pulse_start) begin
			sense_pulse_o <= 1'b1;
			high_cnt_r    <= {`RCJS_CNT_W{1'b0}};
		end else if (sense_pulse_o) begin
			if (rcjs_span_done(high_cnt_r, high_cyc_nxt)) begin
				sense_pulse_o <= 1'b0;
				high_cnt_r    <= {`RCJS_CNT_W{1'b0}};
			end else begin
				high_cnt_r    <= high_cnt_r + {{(`RCJS_CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// sensing enable and coupling kind
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			headset_sense_on_o        <= 1'b0;
			headphone_coupling_kind_o <= 1'b0;
		end else begin
			headset_sense_on_o        <= sense_on;
			headphone_coupling_kind_o <= thresh_r[`RCJS_BIT_COUPLING];
		end
	end

	// hook and microphone limits from coupling and threshold choice
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mic_min_ohm_o  <= `RCJS_MIC_800;
			hook_max_ohm_o <= `RCJS_HOOK_320;
		end else begin
			case ({thresh_r[`RCJS_BIT_COUPLING], thresh_r[`RCJS_BIT_HOOKSEL]})
				2'h0: begin
					mic_min_ohm_o  <= `RCJS_MIC_800;
					hook_max_ohm_o <= `RCJS_HOOK_320;
				end
				2'h1: begin
					mic_min_ohm_o  <= `RCJS_MIC_1350;
					hook_max_ohm_o <= `RCJS_HOOK_680;
				end
				2'h2: begin
					mic_min_ohm_o  <= `RCJS_MIC_800;
					hook_max_ohm_o <= `RCJS_HOOK_150;
				end
				default: begin
					mic_min_ohm_o  <= `RCJS_MIC_1750;
					hook_max_ohm_o <= `RCJS_HOOK_680;
				end
			endcase
		end
	end

endmodule // rcjs_cfg_top

/* File: testbench/rcjs_cfg_checker.sv */
`timescale 1ns/1ns
`include "rcjs_defs.vh"

module rcjs_cfg_checker #(
	parameter [`RCJS_CNT_W-1:0] HIGH4_CYC  = 25'h3,
	parameter [`RCJS_CNT_W-1:0] HIGH32_CYC = 25'h6
) (
	// clock, reset and register port
	input wire                   ref_clk_i,
	input wire                   rst_i,
	input wire                   reg_wr_i,
	input wire                   reg_rd_i,
	input wire [7:0]             reg_addr_i,
	input wire [7:0]             reg_wdata_i,
	input wire [7:0]             reg_rdata_o,
	input wire                   reg_hit_o,
	// derived controls
	input wire                   rate_converter_on_o,
	input wire                   rate_autodetect_on_o,
	input wire                   main_rate_manual_o,
	input wire                   main_rate_source_o,
	input wire [2:0]             ratio_num_o,
	input wire [2:0]             ratio_den_o,
	input wire                   headset_sense_on_o,
	input wire                   sense_pulse_o,
	input wire                   headphone_sense_tick_o,
	input wire                   headphone_coupling_kind_o,
	input wire [`RCJS_OHM_W-1:0] mic_min_ohm_o,
	input wire [`RCJS_OHM_W-1:0] hook_max_ohm_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	// banned ratio codes fall back to auto
	function [2:0] dec(input [2:0] c);
		dec = (c == 3'h5 || c == 3'h7) ? 3'h0 : c;
	endfunction

	// write strobes for registers 0x17, 0x18 and 0x1A
	wire wr17 = reg_wr_i && reg_addr_i == 8'h17;
	wire wr18 = reg_wr_i && reg_addr_i == 8'h18;
	wire wr1a = reg_wr_i && reg_addr_i == 8'h1A;

	// length of the current detection pulse
	reg [`RCJS_CNT_W-1:0] hi_cnt_r;
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			hi_cnt_r <= 25'h0;
		end else begin
			hi_cnt_r <= sense_pulse_o ? hi_cnt_r + 25'h1 : 25'h0;
		end
	end

	conv_on_a: assert property (wr17 |-> ##2 rate_converter_on_o == $past(reg_wdata_i[7], 2))
		else $error("converter enable wrong");
	auto_det_a: assert property (wr17 |-> ##2 rate_autodetect_on_o == !$past(reg_wdata_i[6], 2))
		else $error("autodetect wrong");
	src_sel_a: assert property (wr18 |-> ##2 main_rate_manual_o == $past(reg_wdata_i[7], 2)
		&& main_rate_source_o == ($past(reg_wdata_i[7], 2) && $past(reg_wdata_i[6], 2))) else $error("source wrong");
	ratio_dec_a: assert property (wr18 |-> ##2 ratio_num_o == dec($past(reg_wdata_i[5:3], 2))
		&& ratio_den_o == dec($past(reg_wdata_i[2:0], 2))) else $error("ratio wrong");
	thresh_sel_a: assert property (wr1a |-> ##2 headphone_coupling_kind_o == $past(reg_wdata_i[3], 2)
		&& hook_max_ohm_o == ($past(reg_wdata_i[6], 2) ? 11'h2A8 : $past(reg_wdata_i[3], 2) ? 11'h096 : 11'h140)
		&& mic_min_ohm_o == (!$past(reg_wdata_i[6], 2) ? 11'h320 : $past(reg_wdata_i[3], 2) ? 11'h6D6 : 11'h546))
		else $error("threshold wrong");
	unmapped_rd_a: assert property (reg_rd_i && (reg_addr_i < 8'h17 || reg_addr_i > 8'h1A)
		|=> reg_rdata_o == 8'h00 && !reg_hit_o) else $error("unmapped read wrong");
	ro_bits_a: assert property (reg_rd_i && reg_addr_i == 8'h17 |=> reg_hit_o && reg_rdata_o[5:0] == 6'h00)
		else $error("reserved bits not zero");
	sense_off_a: assert property (!headset_sense_on_o && !$past(headset_sense_on_o) |-> !sense_pulse_o)
		else $error("pulse while sensing off");
	pulse_width_a: assert property ($fell(sense_pulse_o) && headset_sense_on_o
		|-> hi_cnt_r == HIGH4_CYC || hi_cnt_r == HIGH32_CYC) else $error("pulse width wrong");
	tick_one_a: assert property (headphone_sense_tick_o |=> !headphone_sense_tick_o)
		else $error("tick longer than one cycle");

	// main scenarios
	cover property (wr17 ##2 rate_converter_on_o);
	cover property ($rose(sense_pulse_o));
	cover property (headphone_sense_tick_o);
endmodule // rcjs_cfg_checker

bind rcjs_cfg_top rcjs_cfg_checker #(.HIGH4_CYC(HIGH4_CYC), .HIGH32_CYC(HIGH32_CYC)) u_chk (.*);

/* File: testbench/rcjs_host_model.sv */
`timescale 1ns/1ns

module rcjs_host_model (
	// clock
	input  wire       ref_clk_i,
	// register port drive
	output reg        reg_wr_o,
	output reg        reg_rd_o,
	output reg  [7:0] reg_addr_o,
	output reg  [7:0] reg_wdata_o,
	// answer
	input  wire [7:0] reg_rdata_i
);
	// idle port
	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
	end

	// one byte write; read-only reserved bits sent as zero
	task wr(input [7:0] a, input [7:0] d);
		@(posedge ref_clk_i);
		#1;
		reg_wr_o = 1'b1;
		reg_addr_o = a;
		reg_wdata_o = (a == 8'h17) ? (d & 8'hC0) : (a == 8'h1A) ? (d & 8'hFE) : d;
		@(posedge ref_clk_i);
		#1;
		reg_wr_o = 1'b0;
		reg_addr_o = ~a;
		reg_wdata_o = ~reg_wdata_o;
	endtask

	// one byte read, data taken after the answering edge
	task rd(input [7:0] a, output [7:0] d);
		@(posedge ref_clk_i);
		#1;
		reg_rd_o = 1'b1;
		reg_addr_o = a;
		@(posedge ref_clk_i);
		#1;
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
		d = reg_rdata_i;
	endtask
endmodule // rcjs_host_model

/* File: testbench/rate_converter_and_jack_sense_cfg_tb.sv */
`timescale 1ns/1ns
`include "rcjs_defs.vh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module rate_converter_and_jack_sense_cfg_tb;
	reg         ref_clk_i = 1'b0;
	reg         rst_i     = 1'b1;
	wire        wr, rd, hit, on, aut, man, src, sen, pul, tck, cpl;
	wire [7:0]  adr, wd, rdat;
	wire [2:0]  num, den;
	wire [10:0] mic, hook;
	int         n_errors = 0;
	int         total_checks = 0;
	int         i, n, m;
	logic [7:0] d;
	// shortened timer lengths for simulation, every high time below every pulse period
	localparam [24:0] P_0P5 = 25'h28, P_1 = 25'h1E, P_7P5 = 25'h14, P_15 = 25'h10;
	localparam [24:0] H_4 = 25'h3, H_32 = 25'h6, T_1 = 25'h4, T_2 = 25'h6, T_4 = 25'h8;
	int         per_e[4] = '{P_0P5, P_1, P_7P5, P_15};
	int         tk_e[3] = '{T_1, T_2, T_4};
	logic [10:0] mic_e[4] = '{11'h320, 11'h320, 11'h546, 11'h6D6};
	logic [10:0] hook_e[4] = '{11'h140, 11'h096, 11'h2A8, 11'h2A8};

	// 10 MHz clock
	always #50 ref_clk_i = ~ref_clk_i;

	rcjs_cfg_top #(.PER_0P5HZ_CYC(P_0P5), .PER_1HZ_CYC(P_1), .PER_7P5HZ_CYC(P_7P5), .PER_15HZ_CYC(P_15),
		.HIGH4_CYC(H_4), .HIGH32_CYC(H_32), .TICK1_CYC(T_1), .TICK2_CYC(T_2), .TICK4_CYC(T_4)) i_dut (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(adr), .reg_wdata_i(wd),
		.reg_rdata_o(rdat), .reg_hit_o(hit), .rate_converter_on_o(on), .rate_autodetect_on_o(aut),
		.main_rate_manual_o(man), .main_rate_source_o(src), .ratio_num_o(num), .ratio_den_o(den),
		.headset_sense_on_o(sen), .sense_pulse_o(pul), .headphone_sense_tick_o(tck),
		.headphone_coupling_kind_o(cpl), .mic_min_ohm_o(mic), .hook_max_ohm_o(hook));

	rcjs_host_model i_host (.ref_clk_i(ref_clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(adr),
		.reg_wdata_o(wd), .reg_rdata_i(rdat));

	// verdict and end of run
	task wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// read one register and compare
	task automatic rdchk(input [7:0] a, input [7:0] e);
		logic [7:0] v;
		i_host.rd(a, v);
		`CHK("rdata", e, v)
	endtask

	// count cycles until pulse (w=0) or tick (w=1) shows level lv
	task automatic step_until(input int w, input logic lv, output int c);
		c = 0;
		do begin
			@(posedge ref_clk_i);
			#1;
			c++;
			if (c > 200) begin
				n_errors++;
				wrap_up;
			end
		end while ((w ? tck : pul) !== lv);
	endtask

	// main sequence
	initial begin
		repeat (10) @(posedge ref_clk_i);
		#1 rst_i = 1'b0;
		for (i = 8'h17; i <= 8'h1A; i++) rdchk(i[7:0], 8'h00);
		`CHK("autodet", 1'b1, aut)
		$display("reset test done");
		for (i = 0; i < 4; i++) begin
			d = i << 6;
			i_host.wr(8'h17, d);
			rdchk(8'h17, d);
			`CHK("conv_on", d[7], on)
			`CHK("autodet", ~d[6], aut)
		end
		$display("converter test done");
		for (i = 0; i < 7; i++) begin
			if (i == 5) continue;
			d = {i[1:0], i[2:0], i[2:0]};
			i_host.wr(8'h18, d);
			rdchk(8'h18, d);
			`CHK("num", i[2:0], num)
			`CHK("den", i[2:0], den)
			`CHK("manual", d[7], man)
			`CHK("source", d[7] & d[6], src)
		end
		$display("ratio test done");
		i_host.wr(8'h16, 8'hFF);
		i_host.wr(8'h1B, 8'hFF);
		rdchk(8'h1B, 8'h00);
		`CHK("hit", 1'b0, hit)
		rdchk(8'h17, 8'hC0);
		$display("unmapped test done");
		for (i = 0; i < 4; i++) begin
			d = {1'b0, i[1], 2'b00, i[0], 3'b000};
			i_host.wr(8'h1A, d);
			rdchk(8'h1A, d);
			`CHK("coupling", i[0], cpl)
			`CHK("mic", mic_e[i], mic)
			`CHK("hook", hook_e[i], hook)
		end
		$display("threshold test done");
		for (i = 0; i < 4; i++) begin
			i_host.wr(8'h1A, 8'h00);
			i_host.wr(8'h19, {i[1:0], i[0], 2'b00, 2'(i % 3), 1'b0});
			i_host.wr(8'h1A, 8'h02);
			@(posedge ref_clk_i);
			#1;
			`CHK("sense_on", 1'b1, sen)
			step_until(0, 1'b1, n);
			step_until(0, 1'b0, n);
			step_until(0, 1'b1, n);
			step_until(0, 1'b0, n);
			`CHK("high", i[0] ? H_32 : H_4, n)
			step_until(0, 1'b1, m);
			`CHK("period", per_e[i], n + m)
			step_until(1, 1'b1, n);
			step_until(1, 1'b0, n);
			step_until(1, 1'b1, m);
			`CHK("tick", tk_e[i % 3], 1 + m)
		end
		i_host.wr(8'h1A, 8'h00);
		d = 8'h00;
		repeat (60) begin
			@(posedge ref_clk_i);
			#1 d[0] = d[0] | pul;
		end
		`CHK("pulse_off", 1'b0, d[0])
		$display("sensing test done");
		wrap_up;
	end
endmodule // rate_converter_and_jack_sense_cfg_tb
